// ---- core/cprx_regs.svh ----
// register offsets, field positions and counts for the protection status bank
`ifndef CPRX_REGS_SVH
`define CPRX_REGS_SVH
`define CPRX_ADDR_CAPS 8'hA0
`define CPRX_ADDR_TOPO 8'hA1
`define CPRX_ADDR_CASC 8'hA2
`define CPRX_ADDR_KVL 8'hA3
`define CPRX_ADDR_DBG 8'hC0
`define CPRX_CAPS_RESET 8'h13
`define CPRX_TOPO_RESET 8'h00
`define CPRX_CASC_RESET 8'h00
`define CPRX_DBG_RESET 8'h00
`define CPRX_CAPS_MASK 8'h73
`define CPRX_CASC_MASK 8'h0F
`define CPRX_DBG_MASK 8'h0F
`define CPRX_CAPS_RPTR 6
`define CPRX_CAPS_KVL_READY 5
`define CPRX_CAPS_FAST_BUS 4
`define CPRX_CAPS_FEATURES 1
`define CPRX_CAPS_QREAUTH 0
`define CPRX_TOPO_MAXDEV 7
`define CPRX_CASC_MAXCASC 3
`define CPRX_DBG_CHKSUM 3
`define CPRX_DBG_QLINK 2
`define CPRX_DBG_TMR 1
`define CPRX_DBG_QBUS 0
`define CPRX_SHORT_FAST 8'h02
`define CPRX_LONG_FAST 8'h10
`define CPRX_SHORT_SLOW 8'h10
`define CPRX_LONG_SLOW 8'h80
`define CPRX_KVL_DEPTH 128
`define CPRX_KVL_AW 7
`endif

// ---- core/cprx_pkg.sv ----
// types for the protection status bank
package cprx_pkg;
    typedef logic [7:0] cprx_byte_t;
    typedef logic [6:0] cprx_ptr_t;
endpackage : cprx_pkg

// ---- core/cprx_kvl_mem.sv ----
// key-vector list storage, registered read data
`timescale 1ns/10ps
`default_nettype none
`include "cprx_regs.svh"
module cprx_kvl_mem
(
    // clock
    input wire logic clk,
    // write side
    input wire logic wr_en,
    input wire cprx_pkg::cprx_ptr_t wr_addr,
    input wire cprx_pkg::cprx_byte_t wr_data,
    // read side
    input wire cprx_pkg::cprx_ptr_t rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [0:`CPRX_KVL_DEPTH-1];
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule : cprx_kvl_mem
`default_nettype wire

// ---- core/cprx_frame_sched.sv ----
// link-check schedule: frame counter and check pulses
`timescale 1ns/10ps
`default_nettype none
`include "cprx_regs.svh"
module cprx_frame_sched
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // control
    input wire logic quick_link_check,
    input wire logic frame_start,
    // check pulses
    output logic short_check,
    output logic long_check
);
    typedef struct packed
    {
        logic [7:0] frames;
        logic short_p;
        logic long_p;
    } cprx_sched_t;
    cprx_sched_t s_reg, s_next;
    logic [7:0] short_per;
    logic [7:0] long_per;
    always_comb
    begin
        short_per = quick_link_check ? `CPRX_SHORT_FAST : `CPRX_SHORT_SLOW;
        long_per = quick_link_check ? `CPRX_LONG_FAST : `CPRX_LONG_SLOW;
        s_next = s_reg;
        s_next.short_p = 1'b0;
        s_next.long_p = 1'b0;
        if (frame_start)
        begin
            // periods are powers of two, so a free counter serves both
            s_next.frames = s_reg.frames + 8'h01;
            s_next.short_p = (s_reg.frames & (short_per - 8'h01))
                == (short_per - 8'h01);
            s_next.long_p = (s_reg.frames & (long_per - 8'h01))
                == (long_per - 8'h01);
        end
    end
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end
    assign short_check = s_reg.short_p;
    assign long_check = s_reg.long_p;
endmodule : cprx_frame_sched
`default_nettype wire

// ---- core/cprx_status_bank.sv ----
// content-protection receiver status and debug register bank
// Summary of operation
// - capabilities bit 6 shows repeater support, valid once key-ready is set.
// - capabilities bit 5 reads the downstream ready report and clears when a new list starts.
// - capabilities bit 4 reports fast bus support and is otherwise unused.
// - capabilities bit 1 reports enhanced signaling, cipher and checking.
// - capabilities bit 0 reports clear video during re-authentication.
// - topology count bit 7 flags too many downstream devices.
// - topology count bits 6:0 hold device count, zero for a non-repeater.
// - cascade status bit 3 flags more than seven repeater levels.
// - cascade status bits 2:0 give the depth of levels below the repeater.
// - each list port read returns the next list byte.
// - debug bit 3 enables per-line colour channel checksums.
// - debug bit 2 set gives short check every 2, long every 16 frames.
// - debug bit 2 clear gives short every 16, long every 128 frames.
// - debug bit 1 shortens the authentication timers.
// - debug bit 0 selects fast or standard protection-bus timing.
// - the fast-timing bit is mirrored into the indirect status view.
`timescale 1ns/10ps
`default_nettype none
`include "cprx_regs.svh"
module cprx_status_bank
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register access from the control bus slave
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire cprx_pkg::cprx_byte_t reg_addr,
    input wire cprx_pkg::cprx_byte_t reg_wdata,
    output logic [7:0] reg_rdata,
    // back-channel updates from downstream receiver
    input wire logic caps_load,
    input wire cprx_pkg::cprx_byte_t caps_in,
    input wire logic status_load,
    input wire cprx_pkg::cprx_byte_t topo_in,
    input wire cprx_pkg::cprx_byte_t casc_in,
    input wire logic kvl_start,
    input wire logic kvl_wr,
    input wire cprx_pkg::cprx_byte_t kvl_byte,
    input wire logic key_ready,
    input wire logic tx_reset,
    // video timing
    input wire logic frame_start,
    // controls to the transmitter
    output logic line_checksum_enable,
    output logic timer_accelerate,
    output logic protection_bus_quick_timing,
    output logic indirect_status_quick_timing,
    output logic quick_link_check,
    output logic short_link_check_now,
    output logic long_link_check_now,
    output logic repeater_valid
);
    typedef struct packed
    {
        logic [7:0] caps;
        logic [7:0] topo;
        logic [7:0] casc;
        logic [7:0] dbg;
        cprx_pkg::cprx_ptr_t rd_ptr;
        cprx_pkg::cprx_ptr_t wr_ptr;
        logic kvl_pending;
        logic [7:0] rdata;
        logic rptr_valid;
    } cprx_state_t;
    cprx_state_t st_reg, st_next;
    logic [7:0] kvl_rd_data;
    logic sched_short;
    logic sched_long;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction : hit

    cprx_kvl_mem u_mem
    (
        .clk(clk),
        .wr_en(kvl_wr),
        .wr_addr(st_reg.wr_ptr),
        .wr_data(kvl_byte),
        .rd_addr(st_reg.rd_ptr),
        .rd_data(kvl_rd_data)
    );

    cprx_frame_sched u_sched
    (
        .clk(clk),
        .resetn(resetn),
        .quick_link_check(st_reg.dbg[`CPRX_DBG_QLINK]),
        .frame_start(frame_start),
        .short_check(sched_short),
        .long_check(sched_long)
    );

    always_comb
    begin
        st_next = st_reg;
        st_next.kvl_pending = 1'b0;
        if (caps_load)
        begin
            // bit 4 kept for software, never steers the link bus
            st_next.caps = caps_in & `CPRX_CAPS_MASK;
        end
        if (status_load)
        begin
            st_next.topo = topo_in;
            if (!st_reg.caps[`CPRX_CAPS_RPTR])
            begin
                st_next.topo[6:0] = 7'h00;
            end
            st_next.casc = casc_in & `CPRX_CASC_MASK;
        end
        // repeater bit only trusted after key-ready
        st_next.rptr_valid = key_ready & st_reg.caps[`CPRX_CAPS_RPTR];
        if (kvl_wr)
        begin
            st_next.wr_ptr = st_reg.wr_ptr + 7'h01;
        end
        if (reg_wr && hit(reg_addr, `CPRX_ADDR_DBG))
        begin
            st_next.dbg = reg_wdata & `CPRX_DBG_MASK;
        end
        st_next.rdata = 8'h00;
        if (reg_rd)
        begin
            if (hit(reg_addr, `CPRX_ADDR_CAPS))
            begin
                st_next.rdata = st_reg.caps;
            end
            else if (hit(reg_addr, `CPRX_ADDR_TOPO))
            begin
                st_next.rdata = st_reg.topo;
            end
            else if (hit(reg_addr, `CPRX_ADDR_CASC))
            begin
                st_next.rdata = st_reg.casc;
            end
            else if (hit(reg_addr, `CPRX_ADDR_KVL))
            begin
                // memory data is one cycle behind; hold it in the slot
                st_next.kvl_pending = 1'b1;
                st_next.rd_ptr = st_reg.rd_ptr + 7'h01;
            end
            else if (hit(reg_addr, `CPRX_ADDR_DBG))
            begin
                st_next.rdata = st_reg.dbg;
            end
        end
        else
        begin
            st_next.rdata = st_reg.rdata;
        end
        if (st_reg.kvl_pending)
        begin
            st_next.rdata = kvl_rd_data;
        end
        if (kvl_start || tx_reset)
        begin
            st_next.rd_ptr = '0;
            if (kvl_start)
            begin
                st_next.wr_ptr = '0;
                // a ready report landing with the new list wins over the clear
                st_next.caps[`CPRX_CAPS_KVL_READY] =
                    caps_load & caps_in[`CPRX_CAPS_KVL_READY];
            end
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_reg.caps <= `CPRX_CAPS_RESET;
            st_reg.topo <= `CPRX_TOPO_RESET;
            st_reg.casc <= `CPRX_CASC_RESET;
            st_reg.dbg <= `CPRX_DBG_RESET;
            st_reg.rd_ptr <= '0;
            st_reg.wr_ptr <= '0;
            st_reg.kvl_pending <= 1'b0;
            st_reg.rdata <= 8'h00;
            st_reg.rptr_valid <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // outputs straight from flip-flops
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            line_checksum_enable <= 1'b0;
            timer_accelerate <= 1'b0;
            protection_bus_quick_timing <= 1'b0;
            indirect_status_quick_timing <= 1'b0;
            quick_link_check <= 1'b0;
            short_link_check_now <= 1'b0;
            long_link_check_now <= 1'b0;
            repeater_valid <= 1'b0;
        end
        else
        begin
            line_checksum_enable <= st_next.dbg[`CPRX_DBG_CHKSUM];
            timer_accelerate <= st_next.dbg[`CPRX_DBG_TMR];
            protection_bus_quick_timing <= st_next.dbg[`CPRX_DBG_QBUS];
            // same source bit keeps both views identical
            indirect_status_quick_timing <= st_next.dbg[`CPRX_DBG_QBUS];
            quick_link_check <= st_next.dbg[`CPRX_DBG_QLINK];
            short_link_check_now <= sched_short;
            long_link_check_now <= sched_long;
            repeater_valid <= st_next.rptr_valid;
        end
    end
    assign reg_rdata = st_reg.rdata;
endmodule : cprx_status_bank
`default_nettype wire

// ---- tb/cprx_props.sv ----
// assertions on the status bank ports
`timescale 1ns/10ps
`default_nettype none
module cprx_props
(
    // clock, reset, inputs
    input wire logic clk,
    input wire logic resetn,
    input wire logic reg_wr,
    input wire cprx_pkg::cprx_byte_t reg_addr,
    input wire cprx_pkg::cprx_byte_t reg_wdata,
    input wire logic key_ready,
    input wire logic frame_start,
    // outputs
    input wire logic line_checksum_enable,
    input wire logic timer_accelerate,
    input wire logic protection_bus_quick_timing,
    input wire logic indirect_status_quick_timing,
    input wire logic quick_link_check,
    input wire logic short_link_check_now,
    input wire logic long_link_check_now,
    input wire logic repeater_valid
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    sequence s_wr;
        reg_wr && reg_addr == 8'hC0;
    endsequence
    property p_sum;
        s_wr |=> line_checksum_enable == $past(reg_wdata[3]);
    endproperty
    a_sum: assert property (p_sum) else $error("checksum bit");
    property p_tmr;
        s_wr |=> timer_accelerate == $past(reg_wdata[1]);
    endproperty
    a_tmr: assert property (p_tmr) else $error("timer bit");
    property p_qbus;
        s_wr |=> protection_bus_quick_timing == $past(reg_wdata[0]);
    endproperty
    a_qbus: assert property (p_qbus) else $error("bus timing");
    property p_qlc;
        s_wr |=> quick_link_check == $past(reg_wdata[2]);
    endproperty
    a_qlc: assert property (p_qlc) else $error("link check");
    property p_mir;
        indirect_status_quick_timing == protection_bus_quick_timing;
    endproperty
    a_mir: assert property (p_mir) else $error("mirror");
    property p_short;
        short_link_check_now |-> $past(frame_start, 2);
    endproperty
    a_short: assert property (p_short) else $error("short");
    property p_long;
        long_link_check_now |-> short_link_check_now;
    endproperty
    a_long: assert property (p_long) else $error("long");
    // key not ready means the repeater bit cannot be trusted
    property p_rpt;
        !key_ready [*3] |=> !repeater_valid;
    endproperty
    a_rpt: assert property (p_rpt) else $error("repeater");
endmodule : cprx_props
bind cprx_status_bank cprx_props u_props
(
    .clk(clk),
    .resetn(resetn),
    .reg_wr(reg_wr),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .key_ready(key_ready),
    .frame_start(frame_start),
    .line_checksum_enable(line_checksum_enable),
    .timer_accelerate(timer_accelerate),
    .protection_bus_quick_timing(protection_bus_quick_timing),
    .indirect_status_quick_timing(indirect_status_quick_timing),
    .quick_link_check(quick_link_check),
    .short_link_check_now(short_link_check_now),
    .long_link_check_now(long_link_check_now),
    .repeater_valid(repeater_valid)
);
`default_nettype wire

// ---- tb/cprx_rx_model.sv ----
// downstream receiver model on the back channel
`timescale 1ns/10ps
`default_nettype none
module cprx_rx_model
(
    // clock
    input wire logic clk,
    // back channel
    output logic caps_load,
    output logic [7:0] caps_in,
    output logic status_load,
    output logic [7:0] topo_in,
    output logic [7:0] casc_in,
    output logic kvl_start,
    output logic kvl_wr,
    output logic [7:0] kvl_byte,
    output logic key_ready
);
    initial
    begin
        {caps_load, status_load, kvl_start, kvl_wr, key_ready} = 5'h00;
        {caps_in, topo_in, casc_in, kvl_byte} = 32'h00000000;
    end
    task automatic key(input logic v);
        @(posedge clk);
        key_ready <= v;
    endtask : key
    // released bytes flip so stale data never looks valid
    task automatic load(input logic [7:0] c, t, s);
        @(posedge clk);
        caps_load <= 1'b1;
        caps_in <= c;
        @(posedge clk);
        caps_load <= 1'b0;
        caps_in <= ~c;
        status_load <= 1'b1;
        topo_in <= t;
        casc_in <= s;
        @(posedge clk);
        status_load <= 1'b0;
        topo_in <= ~t;
        casc_in <= ~s;
    endtask : load
    task automatic list(input int n, input logic [7:0] b);
        @(posedge clk);
        kvl_start <= 1'b1;
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk);
            kvl_start <= 1'b0;
            kvl_wr <= 1'b1;
            kvl_byte <= b + 8'(i);
        end
        @(posedge clk);
        kvl_wr <= 1'b0;
        kvl_byte <= ~kvl_byte;
    endtask : list
endmodule : cprx_rx_model
`default_nettype wire

// ---- tb/tb_content_protect_rx_status_regs.sv ----
// self-checking bench for the status bank
`timescale 1ns/10ps
`default_nettype none
module tb_content_protect_rx_status_regs;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic reg_rd = 1'b0;
    logic reg_wr = 1'b0;
    logic tx_reset = 1'b0;
    logic frame_start = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata, caps_in, topo_in, casc_in, kvl_byte;
    logic caps_load, status_load, kvl_start, kvl_wr, key_ready;
    logic line_checksum_enable, timer_accelerate, quick_link_check;
    logic protection_bus_quick_timing, indirect_status_quick_timing;
    logic short_link_check_now, long_link_check_now, repeater_valid;
    wire logic [7:0] dbg_o = {4'h0, line_checksum_enable,
        quick_link_check, timer_accelerate, protection_bus_quick_timing};
    int bad_count = 0;
    int checks = 0;
    int n_s = 0;
    int n_l = 0;
    cprx_status_bank dut
    (
        .clk(clk),
        .resetn(resetn),
        .reg_rd(reg_rd),
        .reg_wr(reg_wr),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .caps_load(caps_load),
        .caps_in(caps_in),
        .status_load(status_load),
        .topo_in(topo_in),
        .casc_in(casc_in),
        .kvl_start(kvl_start),
        .kvl_wr(kvl_wr),
        .kvl_byte(kvl_byte),
        .key_ready(key_ready),
        .tx_reset(tx_reset),
        .frame_start(frame_start),
        .line_checksum_enable(line_checksum_enable),
        .timer_accelerate(timer_accelerate),
        .protection_bus_quick_timing(protection_bus_quick_timing),
        .indirect_status_quick_timing(indirect_status_quick_timing),
        .quick_link_check(quick_link_check),
        .short_link_check_now(short_link_check_now),
        .long_link_check_now(long_link_check_now),
        .repeater_valid(repeater_valid)
    );
    cprx_rx_model ds
    (
        .clk(clk),
        .caps_load(caps_load),
        .caps_in(caps_in),
        .status_load(status_load),
        .topo_in(topo_in),
        .casc_in(casc_in),
        .kvl_start(kvl_start),
        .kvl_wr(kvl_wr),
        .kvl_byte(kvl_byte),
        .key_ready(key_ready)
    );
    always #5 clk = ~clk;
    always @(posedge clk)
    begin
        if (short_link_check_now === 1'b1)
            n_s <= n_s + 1;
        if (long_link_check_now === 1'b1)
            n_l <= n_l + 1;
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        cyc(3);
        check(reg_rdata, e);
    endtask : rc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        cyc(1);
    endtask : wr
    task automatic t_dbg;
        rc(8'hA0, 8'h13);
        for (int i = 0; i < 4; i++)
        begin
            wr(8'hC0, 8'h01 << i);
            check(dbg_o, 8'h01 << i);
            check({7'h00, indirect_status_quick_timing}, {7'h00, i == 0});
            rc(8'hC0, 8'h01 << i);
        end
        wr(8'hC0, 8'hFF);
        rc(8'hC0, 8'h0F);
        wr(8'hA0, 8'hFF);
        rc(8'hA0, 8'h13);
    endtask : t_dbg
    task automatic t_caps;
        rc(8'hA1, 8'h00);
        ds.load(8'hFF, 8'h00, 8'h00);
        cyc(1);
        // repeater bit loaded while key still not ready
        check({7'h00, repeater_valid}, 8'h00);
        ds.key(1'b1);
        rc(8'hA0, 8'h73);
        check({7'h00, repeater_valid}, 8'h01);
        ds.load(8'h00, 8'h05, 8'h02);
        rc(8'hA1, 8'h00);
        rc(8'hA2, 8'h02);
        check({7'h00, repeater_valid}, 8'h00);
        ds.load(8'h63, 8'h85, 8'hFB);
        rc(8'hA1, 8'h85);
        rc(8'hA2, 8'h0B);
    endtask : t_caps
    task automatic t_list;
        ds.list(3, 8'h30);
        rc(8'hA0, 8'h43);
        for (int i = 0; i < 3; i++) rc(8'hA3, 8'h30 + 8'(i));
        ds.load(8'h63, 8'h85, 8'hFB);
        rc(8'hA0, 8'h63);
        @(posedge clk);
        tx_reset <= 1'b1;
        @(posedge clk);
        tx_reset <= 1'b0;
        rc(8'hA3, 8'h30);
        ds.list(2, 8'h50);
        rc(8'hA3, 8'h50);
    endtask : t_list
    task automatic frames(input int n);
        n_s = 0;
        n_l = 0;
        repeat (n)
        begin
            @(posedge clk);
            frame_start <= 1'b1;
            @(posedge clk);
            frame_start <= 1'b0;
            cyc(2);
        end
        cyc(4);
    endtask : frames
    task automatic t_frames;
        wr(8'hC0, 8'h04);
        frames(32);
        check(n_s[7:0], 8'h10);
        check(n_l[7:0], 8'h02);
        wr(8'hC0, 8'h00);
        frames(128);
        check(n_s[7:0], 8'h08);
        check(n_l[7:0], 8'h01);
    endtask : t_frames
    initial
    begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        t_dbg();
        t_caps();
        t_list();
        t_frames();
        give_verdict();
    end
    initial
    begin
        #100000;
        bad_count++;
        give_verdict();
    end
endmodule : tb_content_protect_rx_status_regs
`default_nettype wire
